// >>> core/gpcfg_input_filter.sv
// Input conditioner for one pin: two-stage synchroniser and optional
// deglitch filter. Assumes the pin level is sampled on ref_clk.
module gpcfg_input_filter
    import gpcfg_pkg::*;
(
    input  wire logic ref_clk,    // Device clock.
    input  wire logic sys_rst,    // Asynchronous reset, active high.
    input  wire logic pin_in,     // Raw pin level.
    input  wire logic filter_on,  // Demand stability before a change.
    output logic      level       // Conditioned level.
);

    logic             sync_a;
    logic             sync_b;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             next_level;

    // The count restarts whenever the synchronised level bounces.
    always_comb begin
        next_count = '0;
        next_level = level;
        if (!filter_on) begin
            next_level = sync_b;
        end else if (sync_b != level) begin
            if (count == DEGLITCH_LAST) begin
                next_level = sync_b;
            end else begin
                next_count = count + CNT_W'(1);
            end
        end
    end

    // Only the second stage reads the first, to limit metastability.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            count  <= '0;
            level  <= 1'b0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
            count  <= next_count;
            level  <= next_level;
        end
    end

endmodule

// >>> core/gpcfg_pkg.sv
// Shared constants for the three-pin configuration block.
// Assumes a single 125 MHz clock and an 8-bit register access port.
package gpcfg_pkg;

    // Register offsets.
    localparam logic [7:0] PIN_ONE_CONFIG_OFS   = 8'h31;
    localparam logic [7:0] PIN_TWO_CONFIG_OFS   = 8'h32;
    localparam logic [7:0] PIN_THREE_CONFIG_OFS = 8'h33;

    // Values after reset, used until the default memory load arrives.
    localparam logic [7:0] PIN_ONE_CONFIG_RST   = 8'h2A;
    localparam logic [7:0] PIN_TWO_CONFIG_RST   = 8'h0A;
    localparam logic [7:0] PIN_THREE_CONFIG_RST = 8'h0A;

    // Field positions.
    localparam int FUNC_HI    = 7;
    localparam int FUNC_LO    = 5;
    localparam int FILTER_BIT = 4;
    localparam int PULL_BIT   = 3;
    localparam int PULLUP_BIT = 2;
    localparam int OD_BIT     = 1;
    localparam int DIR_BIT    = 0;

    // Function codes.
    localparam logic [2:0] FN_PLAIN   = 3'h0;
    localparam logic [2:0] FN_ALT_A   = 3'h1;
    localparam logic [2:0] FN_ALT_B   = 3'h2;
    localparam logic [2:0] FN_ALT_C   = 3'h3;
    localparam logic [2:0] FN_SLEEP_A = 3'h4;
    localparam logic [2:0] FN_SLEEP_B = 3'h5;
    localparam logic [2:0] FN_WAKE_A  = 3'h6;
    localparam logic [2:0] FN_WAKE_B  = 3'h7;

    // Deglitch time and its cycle count.
    localparam int CLK_MHZ          = 125;
    localparam int DEGLITCH_US      = 8;
    localparam int DEGLITCH_CYCLES  = DEGLITCH_US * CLK_MHZ;
    localparam int CNT_W            = 10;
    localparam logic [CNT_W-1:0] DEGLITCH_LAST =
        CNT_W'(DEGLITCH_CYCLES - 1);

endpackage

// >>> core/gpcfg_top.sv
// Configuration and routing logic for three multi-function pins.
// Assumes an 8-bit register port and a default-memory load strobe.
//
// Behaviour
// - Pin one function code routes its alternate use.
// - Pin one register at 0x31 resets 0x2A.
// - Pin two function code routes its alternate use.
// - Pin three codes two, three select data out.
// - Codes four to seven select sleep, wake.
// - Bit four adds an 8 us deglitch.
// - Bit three enables the pull resistor.
// - Bit two picks up or down, if enabled.
// - Bit one selects open-drain or push-pull.
// - Bit zero sets direction, input after reset.
// - Fields load from non-volatile defaults.
// - Pin two register at 0x32 resets 0x0A.
// - Pin three register at 0x33 resets 0x0A.
module gpcfg_top
    import gpcfg_pkg::*;
(
    input  wire logic       ref_clk,          // Device clock, 125 MHz.
    input  wire logic       sys_rst,          // Async reset, active high.
    input  wire logic [7:0] reg_addr,         // Register offset.
    input  wire logic       reg_wr,           // Write strobe.
    input  wire logic [7:0] reg_wdata,        // Write data.
    output logic      [7:0] reg_rdata,        // Read data, registered.
    input  wire logic       nvm_load,         // Load defaults strobe.
    input  wire logic [7:0] nvm_pin_one,      // Stored default, pin one.
    input  wire logic [7:0] nvm_pin_two,      // Stored default, pin two.
    input  wire logic [7:0] nvm_pin_three,    // Stored default, pin three.
    input  wire logic [2:0] pin_in,           // Pin levels, one to three.
    output logic      [2:0] pin_out,          // Pin drive levels.
    output logic      [2:0] pin_oe_n,         // Low while the pin drives.
    output logic      [2:0] pull_up_on,       // Pull-up resistor enables.
    output logic      [2:0] pull_down_on,     // Pull-down resistor enables.
    input  wire logic [2:0] gpio_out,         // Plain output levels.
    output logic      [2:0] gpio_in,          // Plain input levels.
    input  wire logic       driver_enable_out,     // Pin one function 1.
    input  wire logic       processor_reset_out,   // Pin one function 2.
    input  wire logic       power_good_out,        // Pin one function 3.
    input  wire logic       second_bus_clock_line, // Pin two function 1.
    input  wire logic       spi_select_out,        // Pin two function 2.
    input  wire logic       second_bus_data_line,  // Pin three function 1.
    input  wire logic       serial_port_data_out,  // Pin three, 2 and 3.
    output logic            watchdog_trigger_in,   // Pin two function 3.
    output logic            sleep_request_a,       // Codes 4, any pin.
    output logic            sleep_request_b,       // Codes 5, any pin.
    output logic            wake_input_a,          // Codes 6, any pin.
    output logic            wake_input_b           // Codes 7, any pin.
);

    logic [7:0] pin_one_config;
    logic [7:0] pin_two_config;
    logic [7:0] pin_three_config;
    logic [7:0] next_pin_one_config;
    logic [7:0] next_pin_two_config;
    logic [7:0] next_pin_three_config;
    logic [7:0] next_reg_rdata;
    logic [2:0] level;
    logic [2:0] filter_on;
    logic [2:0] alt_drive;
    logic [2:0] next_pin_out;
    logic [2:0] next_pin_oe_n;
    logic [2:0] next_pull_up_on;
    logic [2:0] next_pull_down_on;
    logic [2:0] next_gpio_in;
    logic       next_watchdog;
    logic [3:0] next_sleep_wake;

    // Function field of a configuration byte.
    function automatic logic [2:0] func_of(input logic [7:0] cfg);
        func_of = cfg[FUNC_HI:FUNC_LO];
    endfunction

    // Does any pin carrying this function code read high?
    function automatic logic any_with(input logic [2:0] code,
                                      input logic [2:0] fa,
                                      input logic [2:0] fb,
                                      input logic [2:0] fc,
                                      input logic [2:0] lv);
        any_with = ((fa == code) & lv[0]) | ((fb == code) & lv[1])
                 | ((fc == code) & lv[2]);
    endfunction

    // Writes win over nothing else; a default load overwrites all fields.
    always_comb begin
        next_pin_one_config   = pin_one_config;
        next_pin_two_config   = pin_two_config;
        next_pin_three_config = pin_three_config;
        if (nvm_load) begin
            next_pin_one_config   = nvm_pin_one;
            next_pin_two_config   = nvm_pin_two;
            next_pin_three_config = nvm_pin_three;
        end else if (reg_wr) begin
            case (reg_addr)
                PIN_ONE_CONFIG_OFS:   next_pin_one_config   = reg_wdata;
                PIN_TWO_CONFIG_OFS:   next_pin_two_config   = reg_wdata;
                PIN_THREE_CONFIG_OFS: next_pin_three_config = reg_wdata;
                default: ;
            endcase
        end
        // Unmapped offsets read zero.
        case (reg_addr)
            PIN_ONE_CONFIG_OFS:   next_reg_rdata = pin_one_config;
            PIN_TWO_CONFIG_OFS:   next_reg_rdata = pin_two_config;
            PIN_THREE_CONFIG_OFS: next_reg_rdata = pin_three_config;
            default:              next_reg_rdata = 8'h00;
        endcase
    end

    // Configuration and read data registers.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_one_config   <= PIN_ONE_CONFIG_RST;
            pin_two_config   <= PIN_TWO_CONFIG_RST;
            pin_three_config <= PIN_THREE_CONFIG_RST;
            reg_rdata        <= 8'h00;
        end else begin
            pin_one_config   <= next_pin_one_config;
            pin_two_config   <= next_pin_two_config;
            pin_three_config <= next_pin_three_config;
            reg_rdata        <= next_reg_rdata;
        end
    end

    assign filter_on = {pin_three_config[FILTER_BIT],
                        pin_two_config[FILTER_BIT],
                        pin_one_config[FILTER_BIT]};

    // One conditioner per pin; the filter only matters for inputs.
    for (genvar i = 0; i < 3; i++) begin : g_in
        gpcfg_input_filter u_filter (
            .ref_clk   (ref_clk),
            .sys_rst   (sys_rst),
            .pin_in    (pin_in[i]),
            .filter_on (filter_on[i]),
            .level     (level[i])
        );
    end

    // Alternate output sources per pin and code; unused codes give 0.
    always_comb begin
        case (func_of(pin_one_config))
            FN_PLAIN: alt_drive[0] = gpio_out[0];
            FN_ALT_A: alt_drive[0] = driver_enable_out;
            FN_ALT_B: alt_drive[0] = processor_reset_out;
            FN_ALT_C: alt_drive[0] = power_good_out;
            default:  alt_drive[0] = 1'b0;
        endcase
        case (func_of(pin_two_config))
            FN_PLAIN: alt_drive[1] = gpio_out[1];
            FN_ALT_A: alt_drive[1] = second_bus_clock_line;
            FN_ALT_B: alt_drive[1] = spi_select_out;
            default:  alt_drive[1] = 1'b0;
        endcase
        case (func_of(pin_three_config))
            FN_PLAIN: alt_drive[2] = gpio_out[2];
            FN_ALT_A: alt_drive[2] = second_bus_data_line;
            FN_ALT_B,
            FN_ALT_C: alt_drive[2] = serial_port_data_out;
            default:  alt_drive[2] = 1'b0;
        endcase
    end

    // Pad controls; open-drain drives only the low level.
    always_comb begin
        logic [7:0] cfg;
        cfg = 8'h00;
        for (int i = 0; i < 3; i++) begin
            case (i)
                0:       cfg = pin_one_config;
                1:       cfg = pin_two_config;
                default: cfg = pin_three_config;
            endcase
            next_pin_out[i] = alt_drive[i];
            if (!cfg[DIR_BIT]) begin
                next_pin_oe_n[i] = 1'b1;
            end else if (cfg[OD_BIT]) begin
                next_pin_out[i]  = 1'b0;
                next_pin_oe_n[i] = alt_drive[i];
            end else begin
                next_pin_oe_n[i] = 1'b0;
            end
            next_pull_up_on[i]   = cfg[PULL_BIT] & cfg[PULLUP_BIT];
            next_pull_down_on[i] = cfg[PULL_BIT] & ~cfg[PULLUP_BIT];
        end
        next_gpio_in = level;
        next_watchdog = (func_of(pin_two_config) == FN_ALT_C) & level[1];
        // Sleep and wake inputs are ORed over all pins carrying them.
        next_sleep_wake[0] = any_with(FN_SLEEP_A, func_of(pin_one_config),
            func_of(pin_two_config), func_of(pin_three_config), level);
        next_sleep_wake[1] = any_with(FN_SLEEP_B, func_of(pin_one_config),
            func_of(pin_two_config), func_of(pin_three_config), level);
        next_sleep_wake[2] = any_with(FN_WAKE_A, func_of(pin_one_config),
            func_of(pin_two_config), func_of(pin_three_config), level);
        next_sleep_wake[3] = any_with(FN_WAKE_B, func_of(pin_one_config),
            func_of(pin_two_config), func_of(pin_three_config), level);
    end

    // Every pad and function output comes from a flip-flop.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out             <= 3'h0;
            pin_oe_n            <= 3'h7;
            pull_up_on          <= 3'h0;
            pull_down_on        <= 3'h0;
            gpio_in             <= 3'h0;
            watchdog_trigger_in <= 1'b0;
            sleep_request_a     <= 1'b0;
            sleep_request_b     <= 1'b0;
            wake_input_a        <= 1'b0;
            wake_input_b        <= 1'b0;
        end else begin
            pin_out             <= next_pin_out;
            pin_oe_n            <= next_pin_oe_n;
            pull_up_on          <= next_pull_up_on;
            pull_down_on        <= next_pull_down_on;
            gpio_in             <= next_gpio_in;
            watchdog_trigger_in <= next_watchdog;
            sleep_request_a     <= next_sleep_wake[0];
            sleep_request_b     <= next_sleep_wake[1];
            wake_input_a        <= next_sleep_wake[2];
            wake_input_b        <= next_sleep_wake[3];
        end
    end

endmodule

// >>> sim/gpcfg_checker.sv
// Checker bound to gpcfg_top; it mirrors the three registers.
// Assumes it sees only the top ports, one clock domain.
module gpcfg_checker
    import gpcfg_pkg::*;
(
    input wire logic       ref_clk,       // Device clock.
    input wire logic       sys_rst,       // Async reset.
    input wire logic [7:0] reg_addr,      // Offset.
    input wire logic       reg_wr,        // Write strobe.
    input wire logic [7:0] reg_wdata,     // Write data.
    input wire logic [7:0] reg_rdata,     // Read data.
    input wire logic       nvm_load,      // Load strobe.
    input wire logic [7:0] nvm_pin_one,   // Default, pin one.
    input wire logic [7:0] nvm_pin_two,   // Default, pin two.
    input wire logic [7:0] nvm_pin_three, // Default, pin three.
    input wire logic [2:0] pin_out,       // Drive levels.
    input wire logic [2:0] pin_oe_n,      // Low while driving.
    input wire logic [2:0] pull_up_on,    // Pull-ups.
    input wire logic [2:0] pull_down_on,  // Pull-downs.
    input wire logic [2:0] gpio_out       // Plain outputs.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cfg [3];
    logic [7:0] next_cfg [3];
    logic [7:0] sel;
    logic [2:0] pu;
    logic [2:0] pd;
    logic [2:0] dir;
    logic [2:0] od;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Mirror update; a load wins over a write in the same cycle.
    always_comb begin
        next_cfg = cfg;
        if (nvm_load) begin
            next_cfg = '{nvm_pin_one, nvm_pin_two, nvm_pin_three};
        end else if (reg_wr && reg_addr[7:2] == 6'h0C
                     && reg_addr[1:0] != 2'h0) begin
            next_cfg[reg_addr[1:0] - 2'h1] = reg_wdata;
        end
    end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg <= '{PIN_ONE_CONFIG_RST, PIN_TWO_CONFIG_RST,
                     PIN_THREE_CONFIG_RST};
        end else begin
            cfg <= next_cfg;
        end
    end
    // Expected read value and pad controls, one cycle ahead of pads.
    always_comb begin
        sel = 8'h00;
        for (int i = 0; i < 3; i++) begin
            pu[i] = cfg[i][PULL_BIT] & cfg[i][PULLUP_BIT];
            pd[i] = cfg[i][PULL_BIT] & ~cfg[i][PULLUP_BIT];
            dir[i] = cfg[i][DIR_BIT];
            od[i] = cfg[i][DIR_BIT] & cfg[i][OD_BIT];
            if (reg_addr == PIN_ONE_CONFIG_OFS + 8'(i)) begin
                sel = cfg[i];
            end
        end
    end
    property p_rdata; 1'b1 |=> reg_rdata == $past(sel); endproperty
    a_rdata: assert property (p_rdata)
        else $error("read data differs from register");
    property p_pull_up; 1'b1 |=> pull_up_on == $past(pu); endproperty
    a_pull_up: assert property (p_pull_up)
        else $error("pull-up enable wrong");
    property p_pull_dn; 1'b1 |=> pull_down_on == $past(pd); endproperty
    a_pull_dn: assert property (p_pull_dn)
        else $error("pull-down enable wrong");
    property p_input; 1'b1 |=> ($past(dir) | pin_oe_n) == 3'h7; endproperty
    a_input: assert property (p_input)
        else $error("input pin is driven");
    property p_od; 1'b1 |=> (pin_out & $past(od)) == 3'h0; endproperty
    a_od: assert property (p_od)
        else $error("open-drain pin drives high");
    property p_pp;
        cfg[0][7:5] == FN_PLAIN && cfg[0][1:0] == 2'h1 |=>
            !pin_oe_n[0] && pin_out[0] == $past(gpio_out[0]);
    endproperty
    a_pp: assert property (p_pp)
        else $error("push-pull plain output wrong");
    property p_load;
        nvm_load ##1 (reg_addr == 8'h32 && !nvm_load && !reg_wr) |=>
            reg_rdata == $past(nvm_pin_two, 2);
    endproperty
    a_load: assert property (p_load)
        else $error("default load not seen");
    property p_rst;
        $fell(sys_rst) |-> pin_oe_n == 3'h7 && pull_up_on == 3'h0;
    endproperty
    a_rst: assert property (p_rst)
        else $error("pads not idle after reset");
endmodule
bind gpcfg_top gpcfg_checker u_checker (.ref_clk, .sys_rst, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rdata, .nvm_load, .nvm_pin_one, .nvm_pin_two,
    .nvm_pin_three, .pin_out, .pin_oe_n, .pull_up_on, .pull_down_on,
    .gpio_out);

// >>> sim/gpcfg_pad_model.sv
// Board model around the three pins: resistors and an outside driver.
// Assumes the pad controls of gpcfg_top and a bench-driven source.
module gpcfg_pad_model (
    input  wire logic       ref_clk,      // Bench clock.
    input  wire logic [2:0] pin_out,      // Device levels.
    input  wire logic [2:0] pin_oe_n,     // Device drives when low.
    input  wire logic [2:0] pull_up_on,   // Pull-up enables.
    input  wire logic [2:0] pull_down_on, // Pull-down enables.
    input  wire logic [2:0] ext_en,       // Outside driver on.
    input  wire logic [2:0] ext_val,      // Outside driver level.
    output logic      [2:0] pin_lvl       // Wire level.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] last = 3'h0;
    // A floating wire toggles each cycle, so a missing pull shows up.
    always @(posedge ref_clk) begin
        last <= pin_lvl;
    end
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (!pin_oe_n[i]) begin
                pin_lvl[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_lvl[i] = ext_val[i];
            end else if (pull_up_on[i] | pull_down_on[i]) begin
                pin_lvl[i] = pull_up_on[i];
            end else begin
                pin_lvl[i] = ~last[i];
            end
        end
    end
endmodule

// >>> sim/tb_gpio_pin_config.sv
// Bench for gpcfg_top with the pad model on its pins.
// Assumes a 125 MHz clock; inputs change on the falling edge.
module tb_gpio_pin_config
    import gpcfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       reg_wr = 1'b0;
    logic       nvm_load = 1'b0;
    logic       wdt;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [7:0] nvm [3] = '{8'h00, 8'h00, 8'h00};
    logic [9:0] src = 10'h000;
    logic [3:0] slp;
    logic [2:0] pin_out, pin_oe_n, pull_up_on, pull_down_on, gpio_in;
    logic [2:0] ext_en = 3'h0;
    logic [2:0] ext_val = 3'h0;
    logic [2:0] pin_lvl;
    int         bad_count = 0;
    int         samples_checked = 0;
    // Pin, function code and index of the source that code routes.
    localparam logic [11:0] ROWS [11] = '{12'h000, 12'h013, 12'h024,
        12'h035, 12'h101, 12'h116, 12'h127, 12'h202, 12'h218, 12'h229,
        12'h239};
    always #4 ref_clk = ~ref_clk;
    gpcfg_top uut (.ref_clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rdata, .nvm_load, .nvm_pin_one(nvm[0]), .nvm_pin_two(nvm[1]),
        .nvm_pin_three(nvm[2]), .pin_in(pin_lvl), .pin_out, .pin_oe_n,
        .pull_up_on, .pull_down_on, .gpio_out(src[2:0]), .gpio_in,
        .driver_enable_out(src[3]), .processor_reset_out(src[4]),
        .power_good_out(src[5]), .second_bus_clock_line(src[6]),
        .spi_select_out(src[7]), .second_bus_data_line(src[8]),
        .serial_port_data_out(src[9]), .watchdog_trigger_in(wdt),
        .sleep_request_a(slp[0]), .sleep_request_b(slp[1]),
        .wake_input_a(slp[2]), .wake_input_b(slp[3]));
    gpcfg_pad_model u_pads (.ref_clk, .pin_out, .pin_oe_n, .pull_up_on,
        .pull_down_on, .ext_en, .ext_val, .pin_lvl);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Write strobe lasts one cycle; the next call starts a cycle later.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        reg_addr = a;
        @(negedge ref_clk);
        check(reg_rdata, exp);
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Watchdog sized well above the roughly 1400 cycles of tests.
    initial begin
        #40000;
        bad_count++;
        stop_test();
    end
    initial begin
        cyc(6);
        sys_rst = 1'b0;
        // Each row drives its routed source high then low, rest opposite.
        foreach (ROWS[r]) begin
            logic [1:0] pn;
            pn = ROWS[r][9:8];
            wr(8'h31 + 8'(ROWS[r][11:8]), {ROWS[r][6:4], 5'h0D});
            for (int v = 0; v < 2; v++) begin
                src = (10'h001 << ROWS[r][3:0]) ^ {10{v[0]}};
                cyc(3);
                check(pin_lvl[pn], !v);
            end
        end
        $display("routing test done");
        for (int p = 0; p < 3; p++) wr(8'h31 + 8'(p), 8'h08);
        wr(8'h32, 8'h60);
        ext_en = 3'h2;
        ext_val = 3'h2;
        cyc(8);
        check(wdt, 1'b1);
        // Pin two back to a pulled-down input, so no pin floats in the sleep and wake loop below.
        wr(8'h32, 8'h08);
        for (int c = 4; c < 8; c++) begin
            for (int p = 0; p < 3; p++) begin
                wr(8'h31 + 8'(p), {c[2:0], 5'h00});
                ext_en = 3'h1 << p;
                ext_val = 3'h1 << p;
                cyc(8);
                check(slp, 4'h1 << (c - 4));
                check({wdt, gpio_in}, {1'b0, 3'h1 << p});
                ext_val = 3'h0;
                cyc(8);
                check(slp, 4'h0);
                wr(8'h31 + 8'(p), 8'h08);
            end
        end
        $display("sleep and wake test done");
        wr(8'h33, 8'h10);
        ext_en = 3'h4;
        ext_val = 3'h4;
        // The change must not pass before 1000 stable cycles.
        cyc(995);
        check(gpio_in[2], 1'b0);
        cyc(10);
        check(gpio_in[2], 1'b1);
        wr(8'h33, 8'h00);
        ext_val = 3'h0;
        cyc(6);
        check(gpio_in[2], 1'b0);
        ext_en = 3'h0;
        $display("deglitch test done");
        wr(8'h31, 8'h0F);
        src = 10'h001;
        cyc(3);
        check({pin_oe_n[0], pin_lvl[0]}, 2'h3);
        src = 10'h000;
        cyc(3);
        check({pin_oe_n[0], pin_out[0]}, 2'h0);
        for (int k = 0; k < 4; k++) begin
            wr(8'h32, 8'(k << 2));
            cyc(2);
            check(pull_up_on[1], k == 3);
            check(pull_down_on[1], k == 2);
        end
        $display("pad control test done");
        wr(8'h34, 8'hFF);
        rd(8'h34, 8'h00);
        wr(8'h31, 8'hA5);
        rd(8'h31, 8'hA5);
        nvm = '{8'h55, 8'h66, 8'h77};
        @(negedge ref_clk);
        {nvm_load, reg_wr, reg_addr, reg_wdata} = {2'h3, 8'h31, 8'h00};
        @(negedge ref_clk);
        {nvm_load, reg_wr, reg_addr} = {2'h0, 8'h32};
        rd(8'h31, 8'h55);
        rd(8'h33, 8'h77);
        @(negedge ref_clk);
        sys_rst = 1'b1;
        cyc(2);
        check({pin_oe_n, pull_up_on}, 6'h38);
        sys_rst = 1'b0;
        rd(8'h31, 8'h2A);
        rd(8'h32, 8'h0A);
        rd(8'h33, 8'h0A);
        $display("register and reset test done");
        stop_test();
    end
endmodule
